// [lie_pkg.sv]
// Package for the load and interrupt instruction execution unit
package lie_pkg;
  // Register byte offsets on the Avalon-MM slave
  localparam logic [7:0] LIE_OFS_CMD = 8'h00;
  localparam logic [7:0] LIE_OFS_SRC_MANT = 8'h04;
  localparam logic [7:0] LIE_OFS_SRC_EXP = 8'h08;
  localparam logic [7:0] LIE_OFS_ADDR = 8'h0C;
  localparam logic [7:0] LIE_OFS_STATE = 8'h10;
  localparam logic [7:0] LIE_OFS_RSEL = 8'h14;
  localparam logic [7:0] LIE_OFS_RDATA_LO = 8'h18;
  localparam logic [7:0] LIE_OFS_RDATA_HI = 8'h1C;
  localparam logic [7:0] LIE_OFS_PC = 8'h20;
  localparam logic [7:0] LIE_OFS_SP = 8'h24;
  localparam logic [7:0] LIE_OFS_FLAGS = 8'h28;
  // Widths
  localparam int LIE_ADDR_W = 24;
  localparam int LIE_EXP_W = 8;
  localparam int LIE_MANT_W = 32;
  localparam int LIE_EXT_REGS = 8;
  localparam int LIE_AUX_REGS = 8;
  // Opcodes, in command bits [3:0]
  typedef enum logic [3:0] {
    LIE_OP_NONE = 4'h0,
    LIE_OP_ACK = 4'h1,
    LIE_OP_IDLE = 4'h2,
    LIE_OP_LDE = 4'h3,
    LIE_OP_LDF = 4'h4,
    LIE_OP_LDF_COND = 4'h5,
    LIE_OP_LDF_LOCK = 4'h6,
    LIE_OP_LDI = 4'h7
  } lie_op_e;
  // Command word layout
  typedef struct packed {
    logic [17:0] unused;
    logic [3:0] cond;
    logic [5:0] dest;
    lie_op_e op;
  } lie_cmd_s;
  // Register indices for the "any register" destination
  localparam logic [5:0] LIE_IDX_AUX_BASE = 6'h08;
  localparam logic [5:0] LIE_IDX_FLAGS = 6'h10;
  localparam logic [5:0] LIE_IDX_SP = 6'h11;
  localparam logic [5:0] LIE_IDX_PC = 6'h12;
  // Status flag bit positions
  localparam int LIE_FLAG_C = 0;
  localparam int LIE_FLAG_V = 1;
  localparam int LIE_FLAG_Z = 2;
  localparam int LIE_FLAG_N = 3;
  localparam int LIE_FLAG_GIE = 13;
  localparam logic [31:0] LIE_FLAGS_RESET = 32'h0000_0000;
  // Condition codes
  localparam logic [3:0] LIE_CC_U = 4'h0;
  localparam logic [3:0] LIE_CC_LO = 4'h1;
  localparam logic [3:0] LIE_CC_HS = 4'h2;
  localparam logic [3:0] LIE_CC_EQ = 4'h3;
  localparam logic [3:0] LIE_CC_NE = 4'h4;
  localparam logic [3:0] LIE_CC_LT = 4'h5;
  localparam logic [3:0] LIE_CC_GE = 4'h6;
  localparam logic [3:0] LIE_CC_GT = 4'h7;
  localparam logic [3:0] LIE_CC_LE = 4'h8;
  localparam logic [3:0] LIE_CC_V = 4'h9;
  localparam logic [3:0] LIE_CC_NV = 4'hA;
  // Interlock indication length on the flag pins
  localparam int LIE_LOCK_NS = 10;
  localparam int LIE_CLK_NS = 5;
  localparam int LIE_LOCK_CYC = (LIE_LOCK_NS + LIE_CLK_NS - 1) / LIE_CLK_NS;
endpackage : lie_pkg

// [lie_exec.sv]
// Load and interrupt instruction execution unit with Avalon-MM register slave
`timescale 1ns/1ps
module lie_exec #(
  parameter logic [lie_pkg::LIE_ADDR_W-1:0] ONCHIP_LIMIT = 24'h00_1000,
  parameter int LOCK_CYCLES = lie_pkg::LIE_LOCK_CYC
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [lie_pkg::LIE_ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  output logic mem_wr,
  output logic [31:0] mem_wdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_wait,
  output logic interrupt_ack_strobe_n,
  input wire logic irq_pin,
  output logic irq_taken,
  output logic external_flag_pin_zero_o,
  output logic external_flag_pin_zero_oe,
  input wire logic external_flag_pin_zero_i,
  output logic external_flag_pin_one_o,
  output logic external_flag_pin_one_oe,
  input wire logic external_flag_pin_one_i
);
  import lie_pkg::*;

  typedef enum logic [4:0] {
    LIE_ST_READY = 5'b00001,
    LIE_ST_ACK = 5'b00010,
    LIE_ST_IDLE = 5'b00100,
    LIE_ST_PUSH = 5'b01000,
    LIE_ST_LOCK = 5'b10000
  } lie_state_e;

  lie_state_e state_reg;
  lie_cmd_s cmd_reg;
  logic [LIE_MANT_W-1:0] src_mant_reg;
  logic [LIE_EXP_W-1:0] src_exp_reg;
  logic [LIE_ADDR_W-1:0] addr_reg;
  logic [5:0] rsel_reg;
  logic [LIE_ADDR_W-1:0] pc_reg;
  logic [LIE_ADDR_W-1:0] sp_reg;
  logic [31:0] flags_reg;
  logic [LIE_EXP_W-1:0] ext_exp_reg [LIE_EXT_REGS];
  logic [LIE_MANT_W-1:0] ext_mant_reg [LIE_EXT_REGS];
  logic [LIE_ADDR_W-1:0] aux_reg [LIE_AUX_REGS];
  logic [1:0] irq_sync_reg;
  logic [1:0] xf0_sync_reg;
  logic [1:0] xf1_sync_reg;
  logic [7:0] lock_cnt_reg;
  logic rd_done_reg;
  logic go;
  logic cond_true;
  logic lie_cond_now;
  lie_cmd_s new_cmd;
  logic [31:0] rd_next;

  // Launch only when idle-ready; a command written while busy is dropped
  assign go = ce && avs_write && avs_address == LIE_OFS_CMD && state_reg == LIE_ST_READY;

  // Reads take one wait cycle so readdata comes from a flop
  assign avs_waitrequest = avs_read && !rd_done_reg;

  // Byte-enable merge for software writes
  function automatic logic [31:0] lie_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] res;
    for (int i = 0; i < 4; i++) begin
      res[i*8 +: 8] = be[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
    return res;
  endfunction : lie_merge

  // Condition from flags as they stand at execution; one evaluator so launch and status cannot disagree
  function automatic logic lie_cond(input logic [3:0] cc, input logic [31:0] fl);
    case (cc)
      LIE_CC_U: return 1'b1;
      LIE_CC_LO: return fl[LIE_FLAG_C];
      LIE_CC_HS: return !fl[LIE_FLAG_C];
      LIE_CC_EQ: return fl[LIE_FLAG_Z];
      LIE_CC_NE: return !fl[LIE_FLAG_Z];
      LIE_CC_LT: return fl[LIE_FLAG_N];
      LIE_CC_GE: return !fl[LIE_FLAG_N];
      LIE_CC_GT: return !fl[LIE_FLAG_N] && !fl[LIE_FLAG_Z];
      LIE_CC_LE: return fl[LIE_FLAG_N] || fl[LIE_FLAG_Z];
      LIE_CC_V: return fl[LIE_FLAG_V];
      LIE_CC_NV: return !fl[LIE_FLAG_V];
      default: return 1'b0;
    endcase
  endfunction : lie_cond
  assign new_cmd = lie_cmd_s'(avs_writedata);
  assign lie_cond_now = lie_cond(new_cmd.cond, flags_reg);
  assign cond_true = lie_cond(cmd_reg.cond, flags_reg);

  // Pin synchronisers; first stage feeds only the second
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_sync_reg <= 2'h0;
      xf0_sync_reg <= 2'h0;
      xf1_sync_reg <= 2'h0;
    end else if (ce) begin
      irq_sync_reg <= {irq_sync_reg[0], irq_pin};
      xf0_sync_reg <= {xf0_sync_reg[0], external_flag_pin_zero_i};
      xf1_sync_reg <= {xf1_sync_reg[0], external_flag_pin_one_i};
    end
  end

  // Command and operand registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmd_reg <= '0;
      src_mant_reg <= 32'h0000_0000;
      src_exp_reg <= 8'h00;
      addr_reg <= 24'h00_0000;
      rsel_reg <= 6'h00;
    end else if (ce && avs_write && !avs_read) begin
      if (go) begin
        cmd_reg <= lie_merge(cmd_reg, avs_writedata, avs_byteenable);
      end
      if (avs_address == LIE_OFS_SRC_MANT) begin
        src_mant_reg <= lie_merge(src_mant_reg, avs_writedata, avs_byteenable);
      end
      if (avs_address == LIE_OFS_SRC_EXP && avs_byteenable[0]) begin
        src_exp_reg <= avs_writedata[LIE_EXP_W-1:0];
      end
      if (avs_address == LIE_OFS_ADDR) begin
        addr_reg <= LIE_ADDR_W'(lie_merge({8'h00, addr_reg}, avs_writedata, avs_byteenable));
      end
      if (avs_address == LIE_OFS_RSEL && avs_byteenable[0]) begin
        rsel_reg <= avs_writedata[5:0];
      end
    end
  end

  // Sequencer for the multi-cycle operations
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_reg <= LIE_ST_READY;
      lock_cnt_reg <= 8'h00;
    end else if (ce) begin
      case (state_reg)
        LIE_ST_READY: begin
          if (go) begin
            case (lie_op_e'(avs_writedata[3:0]))
              LIE_OP_ACK: state_reg <= LIE_ST_ACK;
              LIE_OP_IDLE: state_reg <= LIE_ST_IDLE;
              LIE_OP_LDF_LOCK: begin
                state_reg <= LIE_ST_LOCK;
                lock_cnt_reg <= 8'(LOCK_CYCLES);
              end
              default: state_reg <= LIE_ST_READY;
            endcase
          end
        end
        LIE_ST_ACK: begin
          if (!mem_rd || !mem_wait) begin
            state_reg <= LIE_ST_READY;
          end
        end
        LIE_ST_IDLE: begin
          if (irq_sync_reg[1]) begin
            state_reg <= LIE_ST_PUSH;
          end
        end
        LIE_ST_PUSH: begin
          if (!mem_wait) begin
            state_reg <= LIE_ST_READY;
          end
        end
        LIE_ST_LOCK: begin
          if (lock_cnt_reg <= 8'h01) begin
            state_reg <= LIE_ST_READY;
          end
          lock_cnt_reg <= lock_cnt_reg - 8'h01;
        end
        default: state_reg <= LIE_ST_READY;
      endcase
    end
  end

  // External bus and acknowledge strobe, all from flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      mem_addr <= 24'h00_0000;
      mem_rd <= 1'b0;
      mem_wr <= 1'b0;
      mem_wdata <= 32'h0000_0000;
      interrupt_ack_strobe_n <= 1'b1;
      irq_taken <= 1'b0;
    end else if (ce) begin
      irq_taken <= 1'b0;
      if (state_reg == LIE_ST_READY && go && lie_op_e'(avs_writedata[3:0]) == LIE_OP_ACK) begin
        interrupt_ack_strobe_n <= 1'b0;
        mem_addr <= addr_reg;
        mem_rd <= addr_reg >= ONCHIP_LIMIT;
      end else if (state_reg == LIE_ST_ACK && (!mem_rd || !mem_wait)) begin
        interrupt_ack_strobe_n <= 1'b1;
        mem_rd <= 1'b0;
      end else if (state_reg == LIE_ST_IDLE && irq_sync_reg[1]) begin
        // Pre-increment push of the return address
        mem_addr <= sp_reg + 24'h00_0001;
        mem_wdata <= {8'h00, pc_reg};
        mem_wr <= 1'b1;
      end else if (state_reg == LIE_ST_PUSH && !mem_wait) begin
        mem_wr <= 1'b0;
        irq_taken <= 1'b1;
      end
    end
  end

  // Interlock indication on both flag pins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      external_flag_pin_zero_o <= 1'b0;
      external_flag_pin_zero_oe <= 1'b0;
      external_flag_pin_one_o <= 1'b0;
      external_flag_pin_one_oe <= 1'b0;
    end else if (ce) begin
      if (go && lie_op_e'(avs_writedata[3:0]) == LIE_OP_LDF_LOCK) begin
        external_flag_pin_zero_o <= 1'b1;
        external_flag_pin_zero_oe <= 1'b1;
        external_flag_pin_one_o <= 1'b1;
        external_flag_pin_one_oe <= 1'b1;
      end else if (state_reg == LIE_ST_LOCK && lock_cnt_reg <= 8'h01) begin
        external_flag_pin_zero_o <= 1'b0;
        external_flag_pin_zero_oe <= 1'b0;
        external_flag_pin_one_o <= 1'b0;
        external_flag_pin_one_oe <= 1'b0;
      end
    end
  end

  // Program counter, stack pointer and status flags
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pc_reg <= 24'h00_0000;
      sp_reg <= 24'h00_0000;
      flags_reg <= LIE_FLAGS_RESET;
    end else if (ce) begin
      if (go && lie_op_e'(avs_writedata[3:0]) == LIE_OP_IDLE) begin
        flags_reg[LIE_FLAG_GIE] <= 1'b1;
        pc_reg <= pc_reg + 24'h00_0001;
      end else if (state_reg == LIE_ST_PUSH && !mem_wait) begin
        sp_reg <= sp_reg + 24'h00_0001;
      end else if (state_reg == LIE_ST_READY && avs_write && !avs_read && !go) begin
        if (avs_address == LIE_OFS_PC) begin
          pc_reg <= LIE_ADDR_W'(lie_merge({8'h00, pc_reg}, avs_writedata, avs_byteenable));
        end
        if (avs_address == LIE_OFS_SP) begin
          sp_reg <= LIE_ADDR_W'(lie_merge({8'h00, sp_reg}, avs_writedata, avs_byteenable));
        end
        if (avs_address == LIE_OFS_FLAGS) begin
          flags_reg <= lie_merge(flags_reg, avs_writedata, avs_byteenable);
        end
      end else if (go && lie_op_e'(avs_writedata[3:0]) == LIE_OP_LDI) begin
        // Integer load may target the special registers too
        if (avs_writedata[9:4] == LIE_IDX_FLAGS) begin
          flags_reg <= src_mant_reg;
        end else if (avs_writedata[9:4] == LIE_IDX_SP) begin
          sp_reg <= src_mant_reg[LIE_ADDR_W-1:0];
        end else if (avs_writedata[9:4] == LIE_IDX_PC) begin
          pc_reg <= src_mant_reg[LIE_ADDR_W-1:0];
        end
      end
    end
  end
  // Extended-precision and auxiliary register file
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < LIE_EXT_REGS; i++) begin
        ext_exp_reg[i] <= 8'h00;
        ext_mant_reg[i] <= 32'h0000_0000;
      end
      for (int i = 0; i < LIE_AUX_REGS; i++) begin
        aux_reg[i] <= 24'h00_0000;
      end
    end else if (go) begin
      // Float forms use only the low three bits of the destination
      case (lie_op_e'(avs_writedata[3:0]))
        LIE_OP_LDE: ext_exp_reg[avs_writedata[6:4]] <= src_exp_reg;
        LIE_OP_LDF, LIE_OP_LDF_LOCK: begin
          ext_exp_reg[avs_writedata[6:4]] <= src_exp_reg;
          ext_mant_reg[avs_writedata[6:4]] <= src_mant_reg;
        end
        LIE_OP_LDF_COND: begin
          if (lie_cond_now) begin
            ext_exp_reg[avs_writedata[6:4]] <= src_exp_reg;
            ext_mant_reg[avs_writedata[6:4]] <= src_mant_reg;
          end
        end
        LIE_OP_LDI: begin
          if (avs_writedata[9:4] < LIE_IDX_AUX_BASE) begin
            ext_mant_reg[avs_writedata[6:4]] <= src_mant_reg;
          end else if (avs_writedata[9:4] < LIE_IDX_FLAGS) begin
            aux_reg[avs_writedata[6:4]] <= src_mant_reg[LIE_ADDR_W-1:0];
          end
        end
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_next = 32'h0000_0000;
    case (avs_address)
      LIE_OFS_CMD: rd_next = cmd_reg;
      LIE_OFS_SRC_MANT: rd_next = src_mant_reg;
      LIE_OFS_SRC_EXP: rd_next = {24'h00_0000, src_exp_reg};
      LIE_OFS_ADDR: rd_next = {8'h00, addr_reg};
      LIE_OFS_STATE: rd_next = {xf1_sync_reg[1], xf0_sync_reg[1], interrupt_ack_strobe_n, cond_true,
                                22'h00_0000, 1'b0, state_reg};
      LIE_OFS_RSEL: rd_next = {26'h000_0000, rsel_reg};
      LIE_OFS_RDATA_LO: begin
        if (rsel_reg < LIE_IDX_AUX_BASE) begin
          rd_next = ext_mant_reg[rsel_reg[2:0]];
        end else if (rsel_reg < LIE_IDX_FLAGS) begin
          rd_next = {8'h00, aux_reg[rsel_reg[2:0]]};
        end
      end
      LIE_OFS_RDATA_HI: begin
        if (rsel_reg < LIE_IDX_AUX_BASE) begin
          rd_next = {24'h00_0000, ext_exp_reg[rsel_reg[2:0]]};
        end
      end
      LIE_OFS_PC: rd_next = {8'h00, pc_reg};
      LIE_OFS_SP: rd_next = {8'h00, sp_reg};
      LIE_OFS_FLAGS: rd_next = flags_reg;
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // Registered read data; mem_rdata of the dummy read is discarded
  always_ff @(posedge core_clk) begin
    if (srst) begin
      avs_readdata <= 32'h0000_0000;
      rd_done_reg <= 1'b0;
    end else if (ce) begin
      rd_done_reg <= avs_read && !rd_done_reg;
      if (avs_read && !rd_done_reg) begin
        avs_readdata <= rd_next;
      end
    end
  end

endmodule : lie_exec

// [lie_exec_checker.sv]
// Assertion checker for the load and interrupt execution unit
`timescale 1ns/1ps
module lie_exec_checker #(
  parameter logic [23:0] ONCHIP_LIMIT = 24'h001000,
  parameter int LOCK_CYCLES = 2
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [31:0] mem_wdata,
  input wire logic mem_wait,
  input wire logic interrupt_ack_strobe_n,
  input wire logic irq_taken,
  input wire logic external_flag_pin_zero_o,
  input wire logic external_flag_pin_zero_oe,
  input wire logic external_flag_pin_one_o,
  input wire logic external_flag_pin_one_oe
);
  int lock_cnt;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Cycles the interlock has been shown so far
  always_ff @(posedge core_clk) begin
    if (srst || !external_flag_pin_zero_oe) lock_cnt <= 0;
    else lock_cnt <= lock_cnt + 1;
  end
  property p_ack_ext_read;
    !interrupt_ack_strobe_n && mem_addr >= ONCHIP_LIMIT |-> mem_rd;
  endproperty
  a_ack_ext_read: assert property (p_ack_ext_read) else $error("ack off-chip without read");
  property p_ack_hold;
    !interrupt_ack_strobe_n && mem_rd && mem_wait |=> !interrupt_ack_strobe_n && mem_rd && $stable(mem_addr);
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack strobe left stalled read");
  property p_ack_release;
    !interrupt_ack_strobe_n && (!mem_rd || !mem_wait) |=> interrupt_ack_strobe_n && !mem_rd;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack strobe not released");
  property p_rd_only_ack;
    mem_rd |-> !interrupt_ack_strobe_n;
  endproperty
  a_rd_only_ack: assert property (p_rd_only_ack) else $error("read without ack strobe");
  property p_lock_both;
    external_flag_pin_zero_oe |-> external_flag_pin_one_oe && external_flag_pin_zero_o && external_flag_pin_one_o;
  endproperty
  a_lock_both: assert property (p_lock_both) else $error("interlock not on both pins");
  property p_lock_len;
    $fell(external_flag_pin_zero_oe) |-> lock_cnt == LOCK_CYCLES;
  endproperty
  a_lock_len: assert property (p_lock_len) else $error("interlock length wrong");
  property p_push_hold;
    mem_wr && mem_wait |=> mem_wr && $stable(mem_wdata) && $stable(mem_addr);
  endproperty
  a_push_hold: assert property (p_push_hold) else $error("stalled push changed");
  property p_push_done;
    mem_wr && !mem_wait |=> !mem_wr && irq_taken ##1 !irq_taken;
  endproperty
  a_push_done: assert property (p_push_done) else $error("push end not followed by one taken pulse");
endmodule : lie_exec_checker

// [lie_mem_model.sv]
// Memory bus device model that answers acknowledge reads and stack pushes
`timescale 1ns/1ps
module lie_mem_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic slow,
  input wire logic [23:0] mem_addr,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [31:0] mem_wdata,
  input wire logic interrupt_ack_strobe_n,
  output logic [31:0] mem_rdata,
  output logic mem_wait,
  output int ack_cnt,
  output logic [23:0] ack_addr,
  output int push_cnt,
  output logic [23:0] push_addr,
  output logic [31:0] push_data
);
  initial begin
    mem_wait = 1'b0;
    mem_rdata = 32'h5A5AA5A5;
    ack_cnt = 0;
    push_cnt = 0;
  end
  // Data walks every cycle so a discarded read cannot look stable
  always @(posedge core_clk) begin
    mem_wait <= !srst && slow && ($urandom_range(0, 2) != 0);
    mem_rdata <= {mem_rdata[30:0], ~mem_rdata[31]};
    if (mem_rd && !mem_wait && !interrupt_ack_strobe_n) begin
      ack_cnt <= ack_cnt + 1;
      ack_addr <= mem_addr;
    end
    if (mem_wr && !mem_wait) begin
      push_cnt <= push_cnt + 1;
      push_addr <= mem_addr;
      push_data <= mem_wdata;
    end
  end
endmodule : lie_mem_model

// [tb_load_and_interrupt_instr_exec.sv]
// Self-checking bench for the load and interrupt execution unit
`timescale 1ns/1ps
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin mismatches++; $display("Error at %0t: got %h want %h", $time, g, x); end end
module tb_load_and_interrupt_instr_exec;
  import lie_pkg::*;
  localparam logic [23:0] ONCHIP = 24'h001000;
  logic core_clk = 0, srst = 1, avs_read = 0, avs_write = 0, irq_pin = 0, slow = 0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, mem_rdata, mem_wdata, push_data, rd;
  logic avs_waitrequest, mem_rd, mem_wr, mem_wait, ack_n, irq_taken, x0o, x0e, x1o, x1e;
  logic [23:0] mem_addr, ack_addr, push_addr;
  int ack_cnt, push_cnt, lock_seen = 0, taken = 0, mismatches = 0, compares = 0;
  always #2.5 core_clk = ~core_clk;
  // Flag pins have pull-ups when released
  lie_exec #(.ONCHIP_LIMIT(ONCHIP), .LOCK_CYCLES(2)) u_lie_exec (
    .core_clk(core_clk), .srst(srst), .ce(1'b1), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_wait(mem_wait), .interrupt_ack_strobe_n(ack_n),
    .irq_pin(irq_pin), .irq_taken(irq_taken), .external_flag_pin_zero_o(x0o), .external_flag_pin_zero_oe(x0e),
    .external_flag_pin_zero_i(x0e ? x0o : 1'b1), .external_flag_pin_one_o(x1o),
    .external_flag_pin_one_oe(x1e), .external_flag_pin_one_i(x1e ? x1o : 1'b1));
  lie_mem_model u_lie_mem_model (.core_clk(core_clk), .srst(srst), .slow(slow), .mem_addr(mem_addr),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .interrupt_ack_strobe_n(ack_n),
    .mem_rdata(mem_rdata), .mem_wait(mem_wait), .ack_cnt(ack_cnt), .ack_addr(ack_addr),
    .push_cnt(push_cnt), .push_addr(push_addr), .push_data(push_data));
  // Pin activity counters
  always @(posedge core_clk) begin
    if (x0e === 1'b1 && x1e === 1'b1 && x0o === 1'b1 && x1o === 1'b1) lock_seen <= lock_seen + 1;
    if (irq_taken === 1'b1) taken <= taken + 1;
  end
  task automatic stop_test(input int fail);
    mismatches += fail;
    $display("Compares %0d, mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  // One Avalon transfer; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // Waitrequest and read data are judged at the rising edge, as the slave sees them
    do begin
      @(posedge core_clk);
      n++;
      if (n == 50) stop_test(1);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus
  task automatic wait_ready();
    for (int n = 0; n < 60; n++) begin
      bus(0, LIE_OFS_STATE, 32'h0);
      if (rd[4:0] === 5'h01) return;
    end
    stop_test(1);
  endtask : wait_ready
  task automatic load(input lie_op_e op, input logic [5:0] dst, input logic [3:0] cc, input logic [31:0] m,
      input logic [7:0] e);
    bus(1, LIE_OFS_SRC_MANT, m);
    bus(1, LIE_OFS_SRC_EXP, {24'h0, e});
    bus(1, LIE_OFS_CMD, {18'h0, cc, dst, op});
    wait_ready();
  endtask : load
  task automatic ext(input logic [2:0] r, output logic [31:0] lo, output logic [7:0] hi);
    bus(1, LIE_OFS_RSEL, {29'h0, r});
    bus(0, LIE_OFS_RDATA_LO, 32'h0);
    lo = rd;
    bus(0, LIE_OFS_RDATA_HI, 32'h0);
    hi = rd[7:0];
  endtask : ext
  // Condition outcome from flags C V Z N in bits 0..3
  function automatic logic cond_ok(input logic [3:0] cc, input logic [3:0] f);
    case (cc)
      LIE_CC_U: return 1'b1;
      LIE_CC_LO: return f[0];
      LIE_CC_HS: return !f[0];
      LIE_CC_EQ: return f[2];
      LIE_CC_NE: return !f[2];
      LIE_CC_LT: return f[3];
      LIE_CC_GE: return !f[3];
      LIE_CC_GT: return !f[3] && !f[2];
      LIE_CC_LE: return f[3] || f[2];
      LIE_CC_V: return f[1];
      LIE_CC_NV: return !f[1];
      default: return 1'b0;
    endcase
  endfunction : cond_ok
  initial begin
    logic [31:0] m, lo, pc, sp;
    logic [7:0] e, hi;
    logic [3:0] f;
    int a;
    void'($urandom(32'h16DD06CA));
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    // Float load into every register, upper destination bits ignored
    for (int i = 0; i < 8; i++) begin
      m = $urandom();
      e = 8'($urandom());
      load(LIE_OP_LDF, {3'($urandom()), 3'(i)}, 4'h0, m, e);
      ext(3'(i), lo, hi);
      `CHK(lo, m)
      `CHK(hi, e)
    end
    ext(3'h5, m, e);
    load(LIE_OP_LDE, 6'h05, 4'h0, ~m, ~e);
    ext(3'h5, lo, hi);
    `CHK(lo, m)
    `CHK(hi, ~e)
    // Every condition code against random flags
    for (int c = 0; c < 12; c++) begin
      f = 4'($urandom());
      bus(1, LIE_OFS_FLAGS, {28'h0, f});
      ext(3'h2, m, e);
      load(LIE_OP_LDF_COND, 6'h02, 4'(c), ~m, e);
      ext(3'h2, lo, hi);
      `CHK(lo, (cond_ok(4'(c), f) ? ~m : m))
    end
    m = $urandom();
    load(LIE_OP_LDF_LOCK, 6'h03, 4'h0, m, 8'h11);
    ext(3'h3, lo, hi);
    `CHK(lo, m)
    `CHK(lock_seen, 2)
    m = 32'h80000000 | $urandom();
    load(LIE_OP_LDI, LIE_IDX_SP, 4'h0, m, 8'h00);
    bus(0, LIE_OFS_SP, 32'h0);
    `CHK(rd, {8'h00, m[23:0]})
    load(LIE_OP_LDI, 6'h04, 4'h0, ~m, 8'h00);
    ext(3'h4, lo, hi);
    `CHK(lo, ~m)
    bus(0, 8'hFC, 32'h0);
    `CHK(rd, 32'h0)
    // Acknowledge just below, at and far above the on-chip limit, with a stalling bus
    slow <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      a = ack_cnt;
      m = (i == 0) ? 32'(ONCHIP - 1) : (i == 1) ? 32'(ONCHIP) : {8'hFF, 24'hFFF000 | 24'($urandom())};
      bus(1, LIE_OFS_ADDR, m);
      bus(1, LIE_OFS_CMD, {28'h0, LIE_OP_ACK});
      wait_ready();
      `CHK(ack_cnt, a + (i > 0))
      `CHK(ack_n, 1'b1)
      if (i > 0) `CHK(ack_addr, m[23:0])
    end
    // Idle, a refused command while idle, then the interrupt push
    ext(3'h0, m, e);
    bus(0, LIE_OFS_PC, 32'h0);
    pc = rd;
    bus(0, LIE_OFS_SP, 32'h0);
    sp = rd;
    a = push_cnt;
    bus(1, LIE_OFS_CMD, {28'h0, LIE_OP_IDLE});
    bus(1, LIE_OFS_SRC_MANT, ~m);
    bus(1, LIE_OFS_CMD, {28'h0, LIE_OP_LDF});
    bus(0, LIE_OFS_FLAGS, 32'h0);
    `CHK(rd[LIE_FLAG_GIE], 1'b1)
    bus(0, LIE_OFS_PC, 32'h0);
    `CHK(rd, pc + 1)
    `CHK(push_cnt, a)
    irq_pin <= 1'b1;
    for (int n = 0; push_cnt == a; n++) begin
      if (n == 100) stop_test(1);
      @(negedge core_clk);
    end
    `CHK(push_addr, 24'(sp + 1))
    `CHK(push_data, pc + 1)
    @(posedge core_clk);
    irq_pin <= 1'b0;
    wait_ready();
    `CHK(taken, 1)
    bus(0, LIE_OFS_SP, 32'h0);
    `CHK(rd, {8'h00, 24'(sp + 1)})
    ext(3'h0, lo, hi);
    `CHK(lo, m)
    stop_test(0);
  end
endmodule : tb_load_and_interrupt_instr_exec
bind lie_exec lie_exec_checker #(.ONCHIP_LIMIT(ONCHIP_LIMIT), .LOCK_CYCLES(LOCK_CYCLES)) u_lie_exec_checker (
  .core_clk(core_clk), .srst(srst), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
  .mem_wdata(mem_wdata), .mem_wait(mem_wait), .interrupt_ack_strobe_n(interrupt_ack_strobe_n),
  .irq_taken(irq_taken), .external_flag_pin_zero_o(external_flag_pin_zero_o),
  .external_flag_pin_zero_oe(external_flag_pin_zero_oe), .external_flag_pin_one_o(external_flag_pin_one_o),
  .external_flag_pin_one_oe(external_flag_pin_one_oe));
